/* File: hdl/timer_core.sv */
// timer_core: 16-bit timer/counter with AXI4-Lite registers and one interrupt.
// assumes pins are synchronous to aclk; the instruction clock is aclk itself.
//
// Function
// R1: single 16-bit count register
// R2: may count the low-power 32 kHz oscillator
// R3: async counter mode, no synchroniser delay
// R4: sync mode resynchronises after the prescaler
// R5: timer and gated modes use instruction clock
// R6: both counter modes use external clock pin
// R7: clock source select at control bit 1
// R8: sync select at control bit 2
// R9: gate enable at control bit 6
// R10: source 0: gate picks timer/gated mode
// R11: source 1: sync picks sync/async counter
// R12: usable as RTC or interval timer
// R13: timer_on starts and stops the count
// R14: prescale 1, 8, 64 or 256
// R15: external source counts rising edges
// R16: idle_stop halts counting in idle
// R17: gated mode counts only while gate high
`timescale 1ns/1ps
module timer_core
    import timer_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    // clock, reset, freeze
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        clk_en,
    // timer pins
    input  wire logic                        external_clock_input,
    input  wire logic                        lp_osc_in,
    input  wire logic                        gate_in,
    input  wire logic                        idle_mode,
    // write address
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [timer_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                  awprot,
    // write data
    input  wire logic                        wvalid,
    output logic                             wready,
    input  wire logic [timer_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                  wstrb,
    // write response
    output logic                             bvalid,
    input  wire logic                        bready,
    output logic [1:0]                       bresp,
    // read address
    input  wire logic                        arvalid,
    output logic                             arready,
    input  wire logic [timer_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                  arprot,
    // read data
    output logic                             rvalid,
    input  wire logic                        rready,
    output logic [timer_pkg::DATA_W-1:0]     rdata,
    output logic [1:0]                       rresp,
    // interrupt
    output logic                             irq
);
    import timer_pkg::*;

    if (COUNT_W < 8 || COUNT_W > REG_W) begin : g_bad_width
        $error("timer_core: COUNT_W must lie in 8..16");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                aw_held_q;
    logic                aw_held_d;
    logic                w_held_q;
    logic                w_held_d;
    logic [ADDR_W-1:0]   waddr_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [3:0]          wstrb_q;
    logic                wr_fire;
    logic                wr_hit;
    logic                rd_hit;
    logic [DATA_W-1:0]   rd_word;
    logic [REG_W-1:0]    control_q;
    logic [COUNT_W-1:0]  count_q;
    logic [COUNT_W-1:0]  period_q;
    logic [STATUS_W-1:0] status_q;
    logic [STATUS_W-1:0] enable_q;
    logic [STATUS_W-1:0] status_set;
    logic [STATUS_W-1:0] status_clr;
    logic                ctrl_wr;
    logic                cnt_wr;
    logic                ext_src;
    logic                ext_prev_q;
    logic                ext_rise;
    logic                gate_prev_q;
    logic                run;
    timer_mode_e         mode;
    logic                ps_in;
    logic                ps_out;
    logic                sync_meta_q;
    logic                sync_tick_q;
    logic                count_tick;
    logic                period_hit;

    // ------------------------------------------------------------------
    // register bus: write channel
    // ------------------------------------------------------------------
    // clk_en low freezes the bus as well; masters must not finish a
    // handshake while it is low
    assign wr_fire   = aw_held_q && w_held_q && !bvalid;
    assign aw_held_d = (awvalid && awready) || (aw_held_q && !wr_fire);
    assign w_held_d  = (wvalid && wready) || (w_held_q && !wr_fire);

    always_comb begin
        unique case (waddr_q)
            CONTROL_OFFSET, COUNT_OFFSET, PERIOD_OFFSET, STATUS_OFFSET,
            INT_CLEAR_OFFSET, INT_ENABLE_OFFSET: wr_hit = 1'b1;
            default:                             wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else if (clk_en) begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awready   <= !aw_held_d;
            wready    <= !w_held_d;
            if (awvalid && awready)
                waddr_q <= awaddr;
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready)
                bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register bus: read channel
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (araddr)
            CONTROL_OFFSET:    rd_word[REG_W-1:0]    = control_q;
            COUNT_OFFSET:      rd_word[COUNT_W-1:0]  = count_q;
            PERIOD_OFFSET:     rd_word[COUNT_W-1:0]  = period_q;
            STATUS_OFFSET:     rd_word[STATUS_W-1:0] = status_q;
            INT_CLEAR_OFFSET:  rd_word = '0;
            INT_ENABLE_OFFSET: rd_word[STATUS_W-1:0] = enable_q;
            default:           rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_word;
                rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end else if (!rvalid)
                arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    assign ctrl_wr = wr_fire && waddr_q == CONTROL_OFFSET;
    assign cnt_wr  = wr_fire && waddr_q == COUNT_OFFSET;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            control_q <= CONTROL_RESET;
        else if (clk_en && ctrl_wr)
            control_q <= merge_strb(control_q, wdata_q, wstrb_q) & CONTROL_MASK; // R7 R8 R9
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_q <= COUNT_W'(PERIOD_RESET);
            enable_q <= ENABLE_RESET;
        end else if (clk_en && wr_fire) begin
            if (waddr_q == PERIOD_OFFSET)
                period_q <= COUNT_W'(merge_strb(REG_W'(period_q), wdata_q, wstrb_q));
            if (waddr_q == INT_ENABLE_OFFSET)
                enable_q <= STATUS_W'(merge_strb('0, wdata_q, wstrb_q));
        end
    end

    // ------------------------------------------------------------------
    // clock source, gating and prescaling
    // ------------------------------------------------------------------
    assign mode     = decode_mode(control_q[CLOCK_SRC_BIT], control_q[SYNC_SELECT_BIT],
                                  control_q[GATE_EN_BIT]); // R10 R11
    assign run      = control_q[TIMER_ON_BIT] && !(control_q[IDLE_STOP_BIT] && idle_mode); // R13 R16
    assign ext_src  = control_q[LP_OSC_SELECT_BIT] ? lp_osc_in : external_clock_input; // R2 R12
    assign ext_rise = ext_src && !ext_prev_q; // R15

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev_q  <= 1'b0;
            gate_prev_q <= 1'b0;
        end else if (clk_en) begin
            ext_prev_q  <= ext_src;
            gate_prev_q <= gate_in;
        end
    end

    always_comb begin
        unique case (mode)
            MODE_TIMER:       ps_in = run; // R5
            MODE_GATED:       ps_in = run && gate_in; // R5 R17
            MODE_SYNC_COUNT,
            MODE_ASYNC_COUNT: ps_in = run && ext_rise; // R6 R15
        endcase
    end

    // rewriting control or count restarts the division from zero
    timer_prescaler #(
        .CNT_W (PS_W)
    ) u_prescaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_en    (clk_en),
        .tick_in   (ps_in),
        .clear     (ctrl_wr || cnt_wr),
        .ratio_sel (control_q[PRESCALE_LSB +: 2]),
        .pulse_out (ps_out)
    );

    // sync path costs two cycles of latency; async mode skips it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_meta_q <= 1'b0;
            sync_tick_q <= 1'b0;
        end else if (clk_en) begin
            sync_meta_q <= ps_out && mode == MODE_SYNC_COUNT; // R4
            sync_tick_q <= sync_meta_q;
        end
    end

    assign count_tick = run && (mode == MODE_SYNC_COUNT ? sync_tick_q : ps_out); // R3 R4
    assign period_hit = count_tick && !cnt_wr && count_q == period_q;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            count_q <= COUNT_W'(COUNT_RESET);
        else if (clk_en) begin
            if (cnt_wr)
                count_q <= COUNT_W'(merge_strb(REG_W'(count_q), wdata_q, wstrb_q));
            else if (period_hit)
                count_q <= '0; // R1 R12
            else if (count_tick)
                count_q <= count_q + COUNT_W'(1); // R1
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    always_comb begin
        status_set                  = '0;
        status_set[ST_PERIOD_BIT]   = period_hit;
        status_set[ST_GATE_END_BIT] = mode == MODE_GATED && run && gate_prev_q && !gate_in;
        status_clr = (wr_fire && waddr_q == INT_CLEAR_OFFSET) ?
                     STATUS_W'(merge_strb('0, wdata_q, wstrb_q)) : '0;
    end

    // a new event outranks a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= STATUS_RESET;
            irq      <= 1'b0;
        end else if (clk_en) begin
            status_q <= (status_q & ~status_clr) | status_set;
            irq      <= |(status_q & enable_q);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_stopped;
        (clk_en && !control_q[TIMER_ON_BIT] && !cnt_wr) |=> $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while off"); // R13

    property p_idle_halt;
        (clk_en && control_q[IDLE_STOP_BIT] && idle_mode && !cnt_wr) |=> $stable(count_q);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("count moved in idle"); // R16

    property p_gate_low;
        (clk_en && mode == MODE_GATED && !gate_in && !cnt_wr) |=> $stable(count_q);
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gated count moved"); // R17

    property p_internal_run;
        (clk_en && run && mode == MODE_TIMER && control_q[PRESCALE_LSB +: 2] == 2'h0
         && !cnt_wr && !ctrl_wr && count_q != period_q) |=> count_q == $past(count_q) + COUNT_W'(1);
    endproperty
    a_internal_run: assert property (p_internal_run) else $error("timer mode missed a cycle"); // R5

    sequence s_sync_pipe;
        (clk_en && mode == MODE_SYNC_COUNT && ps_out) ##1 clk_en[*2];
    endsequence
    property p_sync_after;
        s_sync_pipe |-> sync_tick_q;
    endproperty
    a_sync_after: assert property (p_sync_after) else $error("sync tick not two cycles late"); // R4

    property p_async_direct;
        (mode == MODE_ASYNC_COUNT && ps_out) |-> count_tick && !sync_meta_q ##0 1'b1;
    endproperty
    a_async_direct: assert property (p_async_direct) else $error("async tick delayed"); // R3

    property p_ext_edge;
        (clk_en && $past(clk_en) && control_q[CLOCK_SRC_BIT] && run
         && !control_q[LP_OSC_SELECT_BIT] && $rose(external_clock_input)) |-> ps_in;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("pin edge not counted"); // R6

    property p_mode_map;
        (control_q[CLOCK_SRC_BIT] |-> (mode == (control_q[SYNC_SELECT_BIT] ? MODE_SYNC_COUNT
                                                                            : MODE_ASYNC_COUNT)))
        and (!control_q[CLOCK_SRC_BIT] |-> (mode == (control_q[GATE_EN_BIT] ? MODE_GATED : MODE_TIMER)));
    endproperty
    a_mode_map: assert property (p_mode_map) else $error("mode decode wrong"); // R10 R11

    property p_wrap;
        (clk_en && period_hit) |=> count_q == '0 && status_q[ST_PERIOD_BIT];
    endproperty
    a_wrap: assert property (p_wrap) else $error("period match did not wrap"); // R1

endmodule : timer_core

/* File: hdl/timer_pkg.sv */
// timer_pkg: register map, field positions, reset values and decode helpers
// for the 16-bit timer/counter; shared by the core and its prescaler.
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package timer_pkg;

    // ------------------------------------------------------------------
    // widths and bus answers
    // ------------------------------------------------------------------
    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 8;
    localparam int          REG_W       = 16;
    localparam int          PS_W        = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET    = 8'h00;
    localparam logic [ADDR_W-1:0] COUNT_OFFSET      = 8'h04;
    localparam logic [ADDR_W-1:0] PERIOD_OFFSET     = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET     = 8'h0c;
    localparam logic [ADDR_W-1:0] INT_CLEAR_OFFSET  = 8'h10;
    localparam logic [ADDR_W-1:0] INT_ENABLE_OFFSET = 8'h14;

    // ------------------------------------------------------------------
    // timer_control_register fields
    // ------------------------------------------------------------------
    localparam int TIMER_ON_BIT      = 15;
    localparam int IDLE_STOP_BIT     = 13;
    localparam int LP_OSC_SELECT_BIT = 8;
    localparam int GATE_EN_BIT       = 6;
    localparam int PRESCALE_LSB      = 4;
    localparam int SYNC_SELECT_BIT   = 2;
    localparam int CLOCK_SRC_BIT     = 1;
    localparam logic [REG_W-1:0] CONTROL_MASK  = 16'ha176;
    localparam logic [REG_W-1:0] CONTROL_RESET = 16'h0000;
    localparam logic [REG_W-1:0] COUNT_RESET   = 16'h0000;
    localparam logic [REG_W-1:0] PERIOD_RESET  = 16'hffff;

    // ------------------------------------------------------------------
    // status / interrupt layout
    // ------------------------------------------------------------------
    localparam int              STATUS_W        = 2;
    localparam int              ST_PERIOD_BIT   = 0;
    localparam int              ST_GATE_END_BIT = 1;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 2'h0;
    localparam logic [STATUS_W-1:0] ENABLE_RESET = 2'h0;

    // ------------------------------------------------------------------
    // prescaler terminal counts (ratio minus one)
    // ------------------------------------------------------------------
    localparam logic [PS_W-1:0] PS_TERM_1   = 8'h00;
    localparam logic [PS_W-1:0] PS_TERM_8   = 8'h07;
    localparam logic [PS_W-1:0] PS_TERM_64  = 8'h3f;
    localparam logic [PS_W-1:0] PS_TERM_256 = 8'hff;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_SYNC_COUNT,
        MODE_ASYNC_COUNT
    } timer_mode_e;

    function automatic logic [PS_W-1:0] prescale_term(input logic [1:0] sel);
        unique case (sel)
            2'h0: prescale_term = PS_TERM_1;
            2'h1: prescale_term = PS_TERM_8;
            2'h2: prescale_term = PS_TERM_64;
            2'h3: prescale_term = PS_TERM_256;
        endcase
    endfunction : prescale_term

    function automatic timer_mode_e decode_mode(input logic src, input logic sync, input logic gate);
        if (!src)
            decode_mode = gate ? MODE_GATED : MODE_TIMER;
        else
            decode_mode = sync ? MODE_SYNC_COUNT : MODE_ASYNC_COUNT;
    endfunction : decode_mode

    function automatic logic [REG_W-1:0] merge_strb(input logic [REG_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] wd,
                                                    input logic [3:0] strb);
        merge_strb = old_v;
        if (strb[0])
            merge_strb[7:0] = wd[7:0];
        if (strb[1])
            merge_strb[15:8] = wd[15:8];
    endfunction : merge_strb

endpackage : timer_pkg

/* File: hdl/timer_prescaler.sv */
// timer_prescaler: divides a stream of input ticks by 1, 8, 64 or 256.
// assumes ticks are single-cycle qualifiers in the aclk domain.
`timescale 1ns/1ps
module timer_prescaler
    import timer_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clk_en,
    // tick path
    input  wire logic       tick_in,
    input  wire logic       clear,
    input  wire logic [1:0] ratio_sel,
    output logic            pulse_out
);
    import timer_pkg::*;

    if (CNT_W < PS_W) begin : g_bad_width
        $error("timer_prescaler: CNT_W too small for 1:256");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] term;

    assign term      = CNT_W'(prescale_term(ratio_sel));
    assign pulse_out = tick_in && !clear && (cnt_q >= term); // R14

    // a shortened ratio never strands the count above its terminal value
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cnt_q <= '0;
        else if (clk_en) begin
            if (clear || pulse_out)
                cnt_q <= '0;
            else if (tick_in)
                cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_div1;
        @(posedge aclk) disable iff (!aresetn)
        (ratio_sel == 2'h0 && tick_in && !clear) |-> pulse_out;
    endproperty
    a_div1: assert property (p_div1) else $error("1:1 tick not passed"); // R14

    sequence s_eight_ticks;
        (ratio_sel == 2'h1 && tick_in && pulse_out && clk_en)
        ##1 (ratio_sel == 2'h1 && tick_in && !clear && !pulse_out && clk_en)[*7]
        ##1 (ratio_sel == 2'h1 && tick_in && !clear && clk_en);
    endsequence
    property p_div8;
        @(posedge aclk) disable iff (!aresetn)
        s_eight_ticks |-> pulse_out;
    endproperty
    a_div8: assert property (p_div8) else $error("1:8 pulse missing"); // R14

endmodule : timer_prescaler

/* File: verification/ext_clock_src.sv */
// ext_clock_src: far-side source of the count pin and the 32 kHz line
// assumes pulses() is called just after a rising aclk edge
`timescale 1ns/1ps
module ext_clock_src (
    // clock
    input  wire logic aclk,
    // count lines
    output logic      pin,
    output logic      lp
);
    initial begin
        pin = 1'b0;
        lp  = 1'b0;
    end
    // lines rest low between bursts; nothing runs free
    task automatic pulses(input int n, input bit sel, input int hi);
        for (int i = 0; i < n; i++) begin
            if (sel)
                lp <= 1'b1;
            else
                pin <= 1'b1;
            repeat (hi) @(posedge aclk);
            pin <= 1'b0;
            lp  <= 1'b0;
            repeat (hi) @(posedge aclk);
        end
    endtask : pulses
endmodule : ext_clock_src

/* File: verification/tb_timer_core.sv */
// tb_timer_core: self-checking bench for timer_core
// assumes timer_pkg and ext_clock_src are compiled first
`timescale 1ns/1ps
module tb_timer_core;
    import timer_pkg::*;
    logic              aclk, aresetn, clk_en, gate_in, idle_mode;
    logic              awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, irq, pin, lp;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd, c1;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rs;
    logic [7:0]        rnd;
    int                mismatches, n_checks, n, ratio;

    timer_core timer_core_i (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .external_clock_input(pin), .lp_osc_in(lp), .gate_in(gate_in), .idle_mode(idle_mode),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
    ext_clock_src ext_clock_src_i (.aclk(aclk), .pin(pin), .lp(lp));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic stop_test();
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // each channel released at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        awaddr  <= a;
        wdata   <= d;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd_reg

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // about 10k cycles expected; cut off well beyond
    initial begin
        #300us;
        mismatches++;
        stop_test();
    end
    initial begin
        {aresetn, gate_in, idle_mode, awvalid, wvalid, bready, arvalid, rready} = '0;
        clk_en = 1'b1;
        awaddr = '0;
        araddr = '0;
        wdata  = '0;
        wstrb  = 4'hf;
        rnd    = 8'h48;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(CONTROL_OFFSET);
        chk("control", 32'h0, rd);
        rd_reg(PERIOD_OFFSET);
        chk("period", 32'hffff, rd);
        rd_reg(8'h40);
        chk("rresp", 32'h2, 32'(rs));
        wr(8'h40, 32'h0);
        chk("bresp", 32'h2, 32'(rs));
        wr(CONTROL_OFFSET, 32'h7fff);
        rd_reg(CONTROL_OFFSET);
        chk("control", 32'h2176, rd);
        // every prescale, async then sync, gate bit set but ignored
        for (int m = 0; m < 8; m++) begin
            rnd   = lfsr(rnd);
            ratio = (m % 4 == 3) ? 256 : 1 << (3 * (m % 4));
            n     = ratio * (1 + rnd % 3) + rnd % ratio;
            wr(COUNT_OFFSET, 32'h0);
            wr(CONTROL_OFFSET, 32'(32'h8042 | (m / 4) << 2 | (m % 4) << 4 | 32'(m == 7) << 8));
            ext_clock_src_i.pulses(n, m == 7, 2 + 3 * (m % 2));
            repeat (8) @(posedge aclk);
            wr(CONTROL_OFFSET, 32'h0);
            rd_reg(COUNT_OFFSET);
            chk("count", 32'(n / ratio), rd);
        end
        wr(PERIOD_OFFSET, 32'h2);
        wr(COUNT_OFFSET, 32'h0);
        wr(INT_ENABLE_OFFSET, 32'h1);
        wr(CONTROL_OFFSET, 32'h8002);
        ext_clock_src_i.pulses(3, 1'b0, 2);
        repeat (4) @(posedge aclk);
        chk("irq", 32'h1, 32'(irq));
        rd_reg(COUNT_OFFSET);
        chk("count", 32'h0, rd);
        wr(INT_ENABLE_OFFSET, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, 32'(irq));
        wr(INT_ENABLE_OFFSET, 32'h1);
        wr(INT_CLEAR_OFFSET, 32'h1);
        wr(PERIOD_OFFSET, 32'hffff);
        chk("irq", 32'h0, 32'(irq));
        wr(CONTROL_OFFSET, 32'h8040);
        gate_in <= 1'b1;
        repeat (30) @(posedge aclk);
        gate_in <= 1'b0;
        rd_reg(COUNT_OFFSET);
        c1 = rd;
        repeat (20) @(posedge aclk);
        rd_reg(COUNT_OFFSET);
        chk("gated_count", c1, rd);
        chk("gated_moved", 32'h1e, c1);
        rd_reg(STATUS_OFFSET);
        chk("status", 32'h2, rd);
        idle_mode <= 1'b1;
        // idle stop holds the count; then 1:8 and 1:1 runs with idle stop clear
        for (int k = 0; k < 3; k++) begin
            wr(CONTROL_OFFSET, k == 0 ? 32'ha000 : (k == 1 ? 32'h8010 : 32'h8000));
            rd_reg(COUNT_OFFSET);
            c1 = rd;
            repeat (20) @(posedge aclk);
            rd_reg(COUNT_OFFSET);
            chk("count_moved", 32'(k != 0), 32'(rd != c1));
        end
        // clk_en low for 20 cycles: only the 3 enabled edges between the two samples count
        c1 = rd;
        clk_en <= 1'b0;
        repeat (20) @(posedge aclk);
        clk_en <= 1'b1;
        rd_reg(COUNT_OFFSET);
        chk("frozen_count", 32'h3, rd - c1);
        stop_test();
    end
endmodule : tb_timer_core
